//--- hrmd_pkg.sv
// Package for the host register map decoder: offsets, reset values, carriers.
package hrmd_pkg;

	// Fixed register byte offsets in the low window region
	localparam logic [11:0] OFF_FEAT_LO   = 12'h000;
	localparam logic [11:0] OFF_FEAT_HI   = 12'h004;
	localparam logic [11:0] OFF_REVISION  = 12'h008;
	localparam logic [11:0] OFF_MASK_SET  = 12'h00C;
	localparam logic [11:0] OFF_MASK_CLR  = 12'h010;
	localparam logic [11:0] OFF_CONFIG    = 12'h014;
	localparam logic [11:0] OFF_RSVD_18   = 12'h018;
	localparam logic [11:0] OFF_STATUS    = 12'h01C;
	localparam logic [11:0] OFF_SUBSYS    = 12'h020;
	localparam logic [11:0] OFF_AQ_SIZES  = 12'h024;
	localparam logic [11:0] OFF_ASQ_LO    = 12'h028;
	localparam logic [11:0] OFF_ASQ_HI    = 12'h02C;
	localparam logic [11:0] OFF_ACQ_LO    = 12'h030;
	localparam logic [11:0] OFF_ACQ_HI    = 12'h034;
	localparam logic [11:0] OFF_BUF_LOC   = 12'h038;
	localparam logic [11:0] OFF_BUF_SIZE  = 12'h03C;
	localparam logic [11:0] OFF_RSVD_LO   = 12'h040;
	localparam logic [11:0] OFF_CMDSET_LO = 12'hF00;
	localparam int          DB_BASE       = 32'h0000_1000;
	localparam int          DB_WORD_BYTES = 4;

	// Position of the doorbell stride field in the upper feature word
	localparam int          STRIDE_POS    = 0;
	localparam int          STRIDE_BITS   = 4;

	// Reset values of host-writable registers
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;
	localparam logic [63:0] RST_BASE64    = 64'h0000_0000_0000_0000;

	// Low memory base attribute bits: memory space, 64-bit, not prefetchable
	localparam logic [3:0]  BASE_ATTR     = 4'h4;
	localparam int          BASE_ATTR_W   = 4;

	// Default window and doorbell sizing
	localparam int          DEF_WIN_BITS  = 14;
	localparam int          DEF_QUEUES    = 4;
	localparam int          DEF_STRIDE    = 0;

	// Memory request from the host side, one 32-bit word
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [63:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
	} hrmd_req_s;

	// Read answer to the host side
	typedef struct packed {
		logic        valid;
		logic [31:0] rdata;
	} hrmd_rsp_s;

	// Doorbell write toward queue logic
	typedef struct packed {
		logic        valid;
		logic        completion;
		logic [15:0] queue;
		logic [31:0] value;
	} hrmd_bell_s;

	// Software controlled settings toward the controller core
	typedef struct packed {
		logic [31:0] config_word;
		logic [31:0] int_mask;
		logic [31:0] aq_sizes;
		logic [63:0] asq_base;
		logic [63:0] acq_base;
	} hrmd_ctrl_s;

endpackage

//--- hrmd_decoder.sv
// Host register map decoder: window match, fixed registers and doorbells.
`timescale 1ns/1ns
// One 32-bit word per request. A 64-bit register is two independent
// words with no atomic pairing, so software must not expect both
// halves to change together. Doorbell values pass raw, with no range
// check: the queue logic must judge them.
//
module hrmd_decoder #(
	parameter int          WIN_BITS  = hrmd_pkg::DEF_WIN_BITS,
	parameter int          QUEUES    = hrmd_pkg::DEF_QUEUES,
	parameter int          STRIDE    = hrmd_pkg::DEF_STRIDE,
	parameter logic [63:0] FEATURES  = 64'h0000_0000_0000_0000,
	parameter logic [31:0] REVISION  = 32'h0001_0000,
	parameter bit          HAS_SUBSYS = 1'b1,
	parameter bit          HAS_BUFFER = 1'b0,
	parameter logic [31:0] BUF_LOC   = 32'h0000_0000,
	parameter logic [31:0] BUF_SIZE  = 32'h0000_0000
) (
	// Clock and reset
	input  wire logic               clk_sys,
	input  wire logic               sys_rst,
	// Memory base configuration writes
	input  wire logic               cfg_wr,
	input  wire logic               cfg_hi,
	input  wire logic [31:0]        cfg_wdata,
	output logic [63:0]             base_value,
	// Host memory requests and read answers
	input  hrmd_pkg::hrmd_req_s     req,
	output hrmd_pkg::hrmd_rsp_s     rsp,
	// Controller core side
	input  wire logic [31:0]        status_in,
	output hrmd_pkg::hrmd_ctrl_s    ctrl,
	output logic                    subsys_pulse,
	output hrmd_pkg::hrmd_bell_s    bell
);

	////////////////////////////////////////////////////////////////////////
	// Derived sizes

	// Bytes between neighbouring doorbells
	localparam int BELL_STEP  = hrmd_pkg::DB_WORD_BYTES << STRIDE;
	// Supported doorbells: one tail and one head per queue
	localparam int BELLS      = 2 * QUEUES;
	// Vendor range start depends only on supported doorbells and their stride, never on use
	localparam int VEND_START = hrmd_pkg::DB_BASE + BELLS * BELL_STEP;

	////////////////////////////////////////////////////////////////////////
	// Registers and next values

	logic [63:0] base_r,   base_nxt;   // Memory base pair
	logic [31:0] cfg_r,    cfg_nxt;    // Controller configuration
	logic [31:0] mask_r,   mask_nxt;   // Interrupt mask
	logic [31:0] subsys_r, subsys_nxt; // Subsystem reset word
	logic [31:0] aq_r,     aq_nxt;     // Admin queue sizes
	logic [63:0] asq_r,    asq_nxt;    // Admin submission base
	logic [63:0] acq_r,    acq_nxt;    // Admin completion base
	logic        pulse_r,  pulse_nxt;  // Subsystem reset strobe
	hrmd_pkg::hrmd_rsp_s  rsp_r,  rsp_nxt;  // Read answer
	hrmd_pkg::hrmd_bell_s bell_r, bell_nxt; // Doorbell strobe

	// Decode helpers; combinational, so the answer register
	// is the only delay between request and read data
	logic                  hit;       // Request falls inside window
	logic [WIN_BITS-1:0]   off;       // Byte offset in window
	logic [31:0]           lane;      // Byte enables spread to bits
	logic [BELLS-1:0]      bell_hit;  // One-hot doorbell match
	logic [15:0]           bell_idx;  // Encoded doorbell number
	logic                  bell_any;  // Some doorbell matched
	logic [31:0]           rd_word;   // Read mux result

	////////////////////////////////////////////////////////////////////////
	// Window match and byte lanes

	// Upper base bits select the window; low bits address inside it
	always_comb
	begin
		// A miss belongs to some other target and is ignored outright
		hit = req.valid && (req.addr[63:WIN_BITS] == base_r[63:WIN_BITS]);
		off = req.addr[WIN_BITS-1:0];
		// Byte enables only shape writes; reads always return a word
		for (int b = 0; b < 4; b++)
		begin
			lane[b*8 +: 8] = {8{req.be[b]}};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Doorbell array decode

	// One comparator per doorbell word; offsets in a stride gap
	// match nothing and their writes are dropped
	for (genvar i = 0; i < BELLS; i++)
	begin : g_bell
		localparam int BELL_OFF = hrmd_pkg::DB_BASE + i * BELL_STEP;
		assign bell_hit[i] = (32'(off) == BELL_OFF[31:0]);
	end

	// Encode match to a number; only one can ever be set
	always_comb
	begin
		bell_idx = 16'h0000;
		bell_any = 1'b0;
		for (int k = 0; k < BELLS; k++)
		begin
			// Grid offsets never overlap, so at most one match is set
			if (bell_hit[k])
			begin
				bell_idx = 16'(k);
				bell_any = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux

	// Word reads; everything unlisted reads zero
	always_comb
	begin
		rd_word = 32'h0000_0000;
		// Only words below the doorbell base can read nonzero
		if (32'(off) < hrmd_pkg::DB_BASE)
		begin
			unique case (off[11:0])
				hrmd_pkg::OFF_FEAT_LO:  rd_word = FEATURES[31:0];
				hrmd_pkg::OFF_FEAT_HI:  rd_word = stride_word(FEATURES[63:32]);
				hrmd_pkg::OFF_REVISION: rd_word = REVISION;
				hrmd_pkg::OFF_MASK_SET: rd_word = mask_r;
				hrmd_pkg::OFF_MASK_CLR: rd_word = mask_r;
				hrmd_pkg::OFF_CONFIG:   rd_word = cfg_r;
				hrmd_pkg::OFF_STATUS:   rd_word = status_in;
				hrmd_pkg::OFF_SUBSYS:   rd_word = HAS_SUBSYS ? subsys_r : 32'h0000_0000;
				hrmd_pkg::OFF_AQ_SIZES: rd_word = aq_r;
				hrmd_pkg::OFF_ASQ_LO:   rd_word = asq_r[31:0];
				hrmd_pkg::OFF_ASQ_HI:   rd_word = asq_r[63:32];
				hrmd_pkg::OFF_ACQ_LO:   rd_word = acq_r[31:0];
				hrmd_pkg::OFF_ACQ_HI:   rd_word = acq_r[63:32];
				hrmd_pkg::OFF_BUF_LOC:  rd_word = HAS_BUFFER ? BUF_LOC : 32'h0000_0000;
				hrmd_pkg::OFF_BUF_SIZE: rd_word = HAS_BUFFER ? BUF_SIZE : 32'h0000_0000;
				// Reserved word 18h, 40h-EFFh and the command set range
				default:                rd_word = 32'h0000_0000;
			endcase
		end
		// Doorbells are write only and vendor space is empty: both read zero
	end

	// Stride field in the upper feature word follows the stride parameter
	function automatic logic [31:0] stride_word(input logic [31:0] w);
		logic [31:0] r;
		r = w;
		r[hrmd_pkg::STRIDE_POS +: hrmd_pkg::STRIDE_BITS] = STRIDE[hrmd_pkg::STRIDE_BITS-1:0];
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next-value logic

	// Register writes merge by byte lane; writes to unlisted offsets are dropped
	always_comb
	begin
		base_nxt   = base_r;
		cfg_nxt    = cfg_r;
		mask_nxt   = mask_r;
		subsys_nxt = subsys_r;
		aq_nxt     = aq_r;
		asq_nxt    = asq_r;
		acq_nxt    = acq_r;
		pulse_nxt  = 1'b0;
		rsp_nxt    = '0;
		bell_nxt   = '0;

		// Memory base pair; bits below the window size are hardwired zero
		if (cfg_wr)
		begin
			// Each half of the pair is written on its own
			if (cfg_hi)
			begin
				base_nxt[63:32] = cfg_wdata;
			end
			else
			begin
				base_nxt[31:0] = cfg_wdata;
			end
			base_nxt[WIN_BITS-1:0] = '0;
		end

		// Reads answer every hit, mapped or not, one cycle later;
		// a bus error here would upset hosts probing empty space
		if (hit && !req.write)
		begin
			rsp_nxt.valid = 1'b1;
			rsp_nxt.rdata = rd_word;
		end

		// Register writes
		if (hit && req.write && (32'(off) < hrmd_pkg::DB_BASE))
		begin
			unique case (off[11:0])
				// Mask set and clear touch only enabled bytes
				hrmd_pkg::OFF_MASK_SET: mask_nxt = mask_r | (req.wdata & lane);
				hrmd_pkg::OFF_MASK_CLR: mask_nxt = mask_r & ~(req.wdata & lane);
				hrmd_pkg::OFF_CONFIG:   cfg_nxt  = (cfg_r & ~lane) | (req.wdata & lane);
				hrmd_pkg::OFF_SUBSYS:
				begin
					// Core decides whether the written word is a valid trigger
					if (HAS_SUBSYS)
					begin
						subsys_nxt = (subsys_r & ~lane) | (req.wdata & lane);
						pulse_nxt  = 1'b1;
					end
				end
				// Plain storage words merge the enabled bytes
				hrmd_pkg::OFF_AQ_SIZES: aq_nxt = (aq_r & ~lane) | (req.wdata & lane);
				hrmd_pkg::OFF_ASQ_LO:   asq_nxt[31:0]  = (asq_r[31:0] & ~lane) | (req.wdata & lane);
				hrmd_pkg::OFF_ASQ_HI:   asq_nxt[63:32] = (asq_r[63:32] & ~lane) | (req.wdata & lane);
				hrmd_pkg::OFF_ACQ_LO:   acq_nxt[31:0]  = (acq_r[31:0] & ~lane) | (req.wdata & lane);
				hrmd_pkg::OFF_ACQ_HI:   acq_nxt[63:32] = (acq_r[63:32] & ~lane) | (req.wdata & lane);
				// Read-only and reserved words keep their value
				default:                mask_nxt = mask_r;
			endcase
		end

		// Doorbell writes leave as a one-cycle strobe; vendor space drops them
		if (hit && req.write && bell_any && (32'(off) < VEND_START))
		begin
			bell_nxt.valid      = 1'b1;
			bell_nxt.completion = bell_idx[0];
			bell_nxt.queue      = {1'b0, bell_idx[15:1]};
			bell_nxt.value      = req.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State registers

	// Synchronous reset to constants; otherwise take next values
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			// Window falls back to address zero until software places it
			base_r   <= hrmd_pkg::RST_BASE64;
			cfg_r    <= hrmd_pkg::RST_WORD;
			mask_r   <= hrmd_pkg::RST_WORD;
			subsys_r <= hrmd_pkg::RST_WORD;
			aq_r     <= hrmd_pkg::RST_WORD;
			asq_r    <= hrmd_pkg::RST_BASE64;
			acq_r    <= hrmd_pkg::RST_BASE64;
			// Strobes drop to idle so no stale answer or bell leaks out
			pulse_r  <= 1'b0;
			rsp_r    <= '0;
			bell_r   <= '0;
		end
		else
		begin
			base_r   <= base_nxt;
			cfg_r    <= cfg_nxt;
			mask_r   <= mask_nxt;
			subsys_r <= subsys_nxt;
			aq_r     <= aq_nxt;
			asq_r    <= asq_nxt;
			acq_r    <= acq_nxt;
			pulse_r  <= pulse_nxt;
			rsp_r    <= rsp_nxt;
			bell_r   <= bell_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Low base word carries fixed memory attribute bits on read-back
	assign base_value = {base_r[63:hrmd_pkg::BASE_ATTR_W], hrmd_pkg::BASE_ATTR};
	assign rsp        = rsp_r;
	assign bell       = bell_r;
	assign subsys_pulse = pulse_r;
	// Core sees the stored words directly, with no extra stage
	assign ctrl       = '{config_word: cfg_r, int_mask: mask_r, aq_sizes: aq_r,
	                      asq_base: asq_r, acq_base: acq_r};

endmodule

//--- hrmd_decoder_properties.sv
// Port-level concurrent checks for the host register map decoder.
`timescale 1ns/1ns
module hrmd_checker #(
	parameter int          WIN_BITS = 14,
	parameter int          QUEUES   = 4,
	parameter int          STRIDE   = 0,
	parameter logic [31:0] REVISION = 32'h0001_0000
) (
	// Clock and reset
	input wire logic            clk_sys,
	input wire logic            sys_rst,
	// Memory base configuration
	input wire logic            cfg_wr,
	input wire logic            cfg_hi,
	input wire logic [31:0]     cfg_wdata,
	input wire logic [63:0]     base_value,
	// Host requests and answers
	input hrmd_pkg::hrmd_req_s  req,
	input hrmd_pkg::hrmd_rsp_s  rsp,
	// Controller core side
	input wire logic [31:0]     status_in,
	input hrmd_pkg::hrmd_ctrl_s ctrl,
	input wire logic            subsys_pulse,
	input hrmd_pkg::hrmd_bell_s bell
);
	localparam int SPAN = 4 << STRIDE;       // Doorbell spacing in bytes
	localparam int VEND = 2 * QUEUES * SPAN; // Vendor start past 1000h
	logic                hit;  // Request lands in our window
	logic [WIN_BITS-1:0] off;  // Byte offset inside the window
	int                  dbo;  // Offset from the doorbell base, may go negative
	logic                grid; // Offset is a supported doorbell
	assign hit  = req.valid && req.addr[63:WIN_BITS] == base_value[63:WIN_BITS];
	assign off  = req.addr[WIN_BITS-1:0];
	assign dbo  = int'(off) - 32'h1000;
	assign grid = dbo >= 0 && dbo < VEND && dbo % SPAN == 0;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////////////
	// Request shapes
	sequence s_rd;
		hit && !req.write;
	endsequence
	sequence s_wr;
		hit && req.write;
	endsequence
	////////////////////////////////////////////////////////////////////////
	// Properties
	property p_rd_answer; s_rd |=> rsp.valid; endproperty
	property p_no_extra; !(hit && !req.write) |=> !rsp.valid; endproperty
	property p_rsvd_zero; s_rd ##0 (off == 'h18 || off >= 'h40) |=> rsp.rdata == 32'h0; endproperty
	property p_revision; s_rd ##0 off == 'h8 |=> rsp.rdata == REVISION; endproperty
	property p_status; s_rd ##0 off == 'h1C |=> rsp.rdata == $past(status_in); endproperty
	property p_bell;
		s_wr ##0 grid |=> bell.valid && bell.queue == 16'($past(dbo) / (2 * SPAN))
			&& bell.completion == 1'($past(dbo) / SPAN % 2) && bell.value == $past(req.wdata);
	endproperty
	property p_vendor; s_wr ##0 dbo >= VEND |=> !bell.valid; endproperty
	property p_subsys; s_wr ##0 off == 'h20 |=> subsys_pulse; endproperty
	property p_mask;
		s_wr ##0 off == 'hC && req.be == 4'hF |=> ctrl.int_mask == ($past(ctrl.int_mask) | $past(req.wdata));
	endproperty
	property p_base;
		cfg_wr && !cfg_hi |=> base_value[31:WIN_BITS] == $past(cfg_wdata[31:WIN_BITS]) && base_value[3:0] == 4'h4;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read got no answer");
	a_no_extra: assert property (p_no_extra) else $error("answer without a read");
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read not zero");
	a_revision: assert property (p_revision) else $error("revision word wrong");
	a_status: assert property (p_status) else $error("status word wrong");
	a_bell: assert property (p_bell) else $error("doorbell decode wrong");
	a_vendor: assert property (p_vendor) else $error("vendor write rang a doorbell");
	a_subsys: assert property (p_subsys) else $error("subsystem pulse missing");
	a_mask: assert property (p_mask) else $error("mask set wrong");
	a_base: assert property (p_base) else $error("low base word wrong");
endmodule
bind hrmd_decoder hrmd_checker #(.WIN_BITS(WIN_BITS), .QUEUES(QUEUES), .STRIDE(STRIDE), .REVISION(REVISION)) u_chk (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_hi(cfg_hi), .cfg_wdata(cfg_wdata),
	.base_value(base_value), .req(req), .rsp(rsp), .status_in(status_in), .ctrl(ctrl),
	.subsys_pulse(subsys_pulse), .bell(bell));

//--- hrmd_host_model.sv
// Host processor model issuing single-word memory requests.
`timescale 1ns/1ns
module hrmd_host_model (
	// Clock
	input wire logic            clk_sys,
	// Request toward the decoder
	output hrmd_pkg::hrmd_req_s req
);
	initial req = '0;
	// Ordered, unlocked, aligned word access to one register only;
	// read data never steers what the host does next
	task automatic access(input logic w, input logic [63:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_sys);
		req <= '{valid: 1'b1, write: w, addr: a & ~64'h3, wdata: d, be: be};
	endtask
	// Gap cycle, a slow host
	task automatic idle();
		@(posedge clk_sys);
		req.valid <= 1'b0;
	endtask
endmodule

//--- tb_top.sv
// Self-checking testbench for the host register map decoder.
`timescale 1ns/1ns
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin n_fail++; $display("Error at %0t: got %h expected %h", $time, g, x); end end
module tb_top;
	logic                 clk_sys, sys_rst, cfg_wr, cfg_hi, subsys_pulse;
	logic [31:0]          cfg_wdata, status_in, hi, a, b, v;
	logic [63:0]          base_value, base, e;
	hrmd_pkg::hrmd_req_s  req;
	hrmd_pkg::hrmd_rsp_s  rsp;
	hrmd_pkg::hrmd_ctrl_s ctrl;
	hrmd_pkg::hrmd_bell_s bell;
	logic [63:0]          expq[$];    // Expected results, oldest first
	integer               seed = 32'hBCA1;
	int                   n_fail = 0, checks = 0;
	int                   n_pulse = 0; // Subsystem reset strobes seen
	logic [13:0]          ro_off[10] = '{14'h0, 14'h4, 14'h8, 14'h18, 14'h38, 14'h3C, 14'h40, 14'hEFC, 14'hF00, 14'h1020};
	logic [13:0]          rw_off[7] = '{14'h14, 14'h20, 14'h24, 14'h28, 14'h2C, 14'h30, 14'h34};
	logic [31:0]          rw_val[7];
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	hrmd_host_model host (.clk_sys(clk_sys), .req(req));
	hrmd_decoder dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_hi(cfg_hi), .cfg_wdata(cfg_wdata),
		.base_value(base_value), .req(req), .rsp(rsp), .status_in(status_in), .ctrl(ctrl),
		.subsys_pulse(subsys_pulse), .bell(bell));
	////////////////////////////////////////////////////////////////////////
	// Pair each answer or doorbell with the oldest note; empty queue never matches
	always @(posedge clk_sys)
	begin
		if (subsys_pulse)
			n_pulse++;
		if (rsp.valid || bell.valid)
		begin
			e = (expq.size() > 0) ? expq.pop_front() : 64'hFFFF_FFFF_FFFF_FFFF;
			if (rsp.valid)
				`CHK({32'h0, rsp.rdata}, e)
			else
				`CHK({15'h0, bell.queue, bell.completion, bell.value}, e)
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Bus helpers on the current window base
	task automatic wr(input logic [13:0] o, input logic [31:0] d, input logic [3:0] be = 4'hF);
		host.access(1'b1, base + 64'(o), d, be);
	endtask
	task automatic rd(input logic [13:0] o, input logic [31:0] x);
		expq.push_back({32'h0, x});
		host.access(1'b0, base + 64'(o), 32'h0, 4'h0);
	endtask
	task automatic set_base(input logic h, input logic [31:0] d);
		@(posedge clk_sys);
		cfg_wr <= 1'b1;
		cfg_hi <= h;
		cfg_wdata <= d;
		@(posedge clk_sys);
		cfg_wr <= 1'b0;
	endtask
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Hang guard, well past the roughly 75 cycles of the run
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		n_fail++;
		finish_test();
	end
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		{sys_rst, cfg_wr, cfg_hi, cfg_wdata, status_in, base} = {1'b1, 130'h0};
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		#1 `CHK(base_value, 64'h4)
		hi = $random(seed);
		set_base(1'b1, hi);
		set_base(1'b0, 32'h0001_2345);
		#1 base = {hi, 32'h0001_0000};
		`CHK(base_value, base | 64'h4)
		// Writes to read-only, reserved and vendor words leave them as they were
		foreach (ro_off[i]) wr(ro_off[i], $random(seed));
		foreach (ro_off[i]) rd(ro_off[i], (ro_off[i] == 14'h8) ? 32'h0001_0000 : 32'h0);
		foreach (rw_off[i])
		begin
			rw_val[i] = $random(seed);
			wr(rw_off[i], rw_val[i]);
		end
		foreach (rw_off[i]) rd(rw_off[i], rw_val[i]);
		`CHK(ctrl.aq_sizes, rw_val[2])
		`CHK(ctrl.asq_base, {rw_val[4], rw_val[3]})
		`CHK(ctrl.acq_base, {rw_val[6], rw_val[5]})
		a = $random(seed);
		b = $random(seed);
		wr(14'hC, a);
		host.idle();
		wr(14'h10, b);
		wr(14'hC, 32'hFFFF_FFFF, 4'h2);
		rd(14'h10, (a & ~b) | 32'h0000_FF00);
		host.idle();
		`CHK(ctrl.int_mask, (a & ~b) | 32'h0000_FF00)
		status_in <= a;
		rd(14'h1C, a);
		for (int q = 0; q < 2 * hrmd_pkg::DEF_QUEUES; q++)
		begin
			v = $random(seed);
			expq.push_back({15'h0, 16'(q / 2), q[0], v});
			wr(14'h1000 + 14'(q * (4 << hrmd_pkg::DEF_STRIDE)), v);
		end
		wr(14'h1020, v);
		rd(14'h1000, 32'h0);
		host.access(1'b0, base ^ 64'h0000_0001_0000_0000, 32'h0, 4'h0);
		host.idle();
		sys_rst <= 1'b1;
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		base = 64'h0;
		@(posedge clk_sys);
		#1 `CHK(base_value, 64'h4)
		`CHK(ctrl.config_word, 32'h0)
		rd(14'h14, 32'h0);
		host.idle();
		repeat (4) @(posedge clk_sys);
		`CHK(expq.size(), 0)
		`CHK(n_pulse, 1)
		finish_test();
	end
endmodule
